// ---- core/ucrl_regs.vh ----
`ifndef UCRL_REGS_VH
`define UCRL_REGS_VH

// ************************************************
// Register slots (three address lines)
// ************************************************
`define UCRL_A_DATA      3'h0
`define UCRL_A_MASK      3'h1
`define UCRL_A_CAUSE     3'h2
`define UCRL_A_FORMAT    3'h3
`define UCRL_A_MODEM     3'h4
`define UCRL_A_LSTATE    3'h5
`define UCRL_A_MSTATE    3'h6
`define UCRL_A_SCRATCH   3'h7

// ************************************************
// Field positions and keys
// ************************************************
`define UCRL_FMT_DLAB    7
`define UCRL_FMT_BREAK   6
`define UCRL_FMT_FORCE   5
`define UCRL_FMT_EVEN    4
`define UCRL_FMT_PAREN   3
`define UCRL_FMT_STOP    2
`define UCRL_MDM_DTR     0
`define UCRL_MDM_RTS     1
`define UCRL_MDM_OUT2    3
`define UCRL_MDM_LOOP    4
`define UCRL_EFR_ENH     4
`define UCRL_QC_FIFO     0
`define UCRL_QC_DMA      3
`define UCRL_ENH_KEY     8'hBF
`define UCRL_EXT_MASK4   8'h0F
`define UCRL_EXT_MASK5   8'h1F

// ************************************************
// Interrupt cause codes and reset values
// ************************************************
`define UCRL_ID_NONE     8'h01
`define UCRL_ID_LINE     8'h06
`define UCRL_ID_RXD      8'h04
`define UCRL_ID_TXE      8'h02
`define UCRL_ID_MODEM    8'h00
`define UCRL_RST_BYTE    8'h00

`endif

// ---- core/ucrl_top.v ----
`timescale 1ns/1ps
`include "ucrl_regs.vh"

module ucrl_top #(
	parameter       CHAN       = 1'b0,
	parameter [7:0] REV_CODE   = 8'h01,  // Arbitrary value
	parameter [7:0] IDENT_CODE = 8'h5A   // Arbitrary value
) (
	input  wire       mclk,
	input  wire       rstn,
	input  wire       cs_n,
	input  wire       channel_select,
	input  wire [2:0] addr,
	input  wire       rd_n,
	input  wire       wr_n,
	input  wire [7:0] wdata,
	output reg  [7:0] rdata,
	output reg        data_oe_n,
	input  wire       rx_in,
	input  wire       cts_n,
	input  wire       dsr_n,
	input  wire       carrier_detect_n,
	input  wire       ring_indicate_n,
	output reg        tx_out,
	output reg        rts_n,
	output reg        dtr_n,
	output reg        general_output_two_n
);

	// ************************************************
	// Register storage
	// ************************************************
	reg  [7:0]  line_format_r;
	reg  [7:0]  modem_outputs_r;
	reg  [7:0]  interrupt_mask_r;
	reg  [7:0]  queue_control_r;
	reg  [7:0]  divisor_low_r;
	reg  [7:0]  divisor_high_r;
	reg  [7:0]  alt_function_r;
	reg  [7:0]  enhanced_features_r;
	reg  [7:0]  resume_char_one_r;
	reg  [7:0]  resume_char_two_r;
	reg  [7:0]  pause_char_one_r;
	reg  [7:0]  pause_char_two_r;
	reg  [7:0]  scratch_r;
	reg  [7:0]  tx_holding_r;
	reg  [7:0]  rx_holding_r;
	reg         thr_full_r;
	reg         thre_int_r;
	reg         rx_ready_r;
	reg         overrun_r;
	reg         par_err_r;
	reg         frm_err_r;
	reg         brk_r;
	reg  [3:0]  mdm_prev_r;
	reg  [3:0]  mdm_delta_r;
	reg         rd_q_r;
	reg         wr_q_r;

	// ************************************************
	// Host strobe qualification and view decode
	// ************************************************
	wire        sel      = ~cs_n & (channel_select == CHAN);
	wire        rd_go    = sel & ~rd_n & rd_q_r;
	wire        wr_go    = sel & ~wr_n & wr_q_r;
	wire        enh_view = (line_format_r == `UCRL_ENH_KEY);
	wire        dlab     = line_format_r[`UCRL_FMT_DLAB];
	wire        div_zero = (divisor_low_r == 8'h00) & (divisor_high_r == 8'h00);
	wire        ext_en   = enhanced_features_r[`UCRL_EFR_ENH];
	wire        loop     = modem_outputs_r[`UCRL_MDM_LOOP];
	wire [15:0] divisor  = {divisor_high_r, divisor_low_r};

	// Extended bits read as zero unless the enhanced bit is set
	wire [7:0]  mask_vis = ext_en ? interrupt_mask_r : (interrupt_mask_r & `UCRL_EXT_MASK4);
	wire [7:0]  mdm_vis  = ext_en ? modem_outputs_r : (modem_outputs_r & `UCRL_EXT_MASK5);

	// ************************************************
	// Modem status, with loopback substitution
	// ************************************************
	wire [3:0]  mdm_now = loop ?
		{modem_outputs_r[`UCRL_MDM_OUT2], 1'b0, modem_outputs_r[`UCRL_MDM_DTR], modem_outputs_r[`UCRL_MDM_RTS]} :
		{~carrier_detect_n, ~ring_indicate_n, ~dsr_n, ~cts_n};
	wire [3:0]  mdm_chg = (mdm_now ^ mdm_prev_r) & {1'b1, ~mdm_now[2], 2'b11};
	wire [7:0]  modem_inputs = {mdm_prev_r, mdm_delta_r};
	wire        tx_idle;
	wire [7:0]  line_state = {queue_control_r[`UCRL_QC_FIFO] & (par_err_r | frm_err_r | brk_r),
		tx_idle, ~thr_full_r, brk_r, frm_err_r, par_err_r, overrun_r, rx_ready_r};

	// ************************************************
	// Interrupt cause, highest priority first
	// ************************************************
	reg  [7:0]  cause_id;
	always @* begin
		if (mask_vis[2] & (overrun_r | par_err_r | frm_err_r | brk_r))
			cause_id = `UCRL_ID_LINE;
		else if (mask_vis[0] & rx_ready_r)
			cause_id = `UCRL_ID_RXD;
		else if (mask_vis[1] & thre_int_r)
			cause_id = `UCRL_ID_TXE;
		else if (mask_vis[3] & (|mdm_delta_r))
			cause_id = `UCRL_ID_MODEM;
		else
			cause_id = `UCRL_ID_NONE;
	end
	// Bits 5:4 carry sources outside this block, so they stay zero
	wire [7:0]  interrupt_cause = {{2{queue_control_r[`UCRL_QC_FIFO]}}, 2'b00, cause_id[3:0]};

	// ************************************************
	// Read multiplexer
	// ************************************************
	reg  [7:0]  rd_val;
	always @* begin
		case (addr)
			`UCRL_A_DATA:    rd_val = dlab ? (div_zero ? REV_CODE : divisor_low_r) : rx_holding_r;
			`UCRL_A_MASK:    rd_val = dlab ? (div_zero ? IDENT_CODE : divisor_high_r) : mask_vis;
			`UCRL_A_CAUSE:   rd_val = enh_view ? enhanced_features_r :
			                          (dlab ? alt_function_r : interrupt_cause);
			`UCRL_A_FORMAT:  rd_val = line_format_r;
			`UCRL_A_MODEM:   rd_val = enh_view ? resume_char_one_r : mdm_vis;
			`UCRL_A_LSTATE:  rd_val = enh_view ? resume_char_two_r : line_state;
			`UCRL_A_MSTATE:  rd_val = enh_view ? pause_char_one_r : modem_inputs;
			`UCRL_A_SCRATCH: rd_val = enh_view ? pause_char_two_r : scratch_r;
			default:         rd_val = `UCRL_RST_BYTE;
		endcase
	end

	wire rd_rhr = rd_go & (addr == `UCRL_A_DATA) & ~dlab;
	wire rd_isr = rd_go & (addr == `UCRL_A_CAUSE) & ~dlab;
	wire rd_lsr = rd_go & (addr == `UCRL_A_LSTATE) & ~enh_view;
	wire rd_msr = rd_go & (addr == `UCRL_A_MSTATE) & ~enh_view;
	wire wr_thr = wr_go & (addr == `UCRL_A_DATA) & ~dlab;

	// ************************************************
	// Bit clock from the 16-bit divisor
	// ************************************************
	reg  [15:0] baud_cnt_r;
	wire        div_wr = wr_go & dlab & (addr[2:1] == 2'b00);  // Restart so a stale long count cannot delay a new rate
	wire        tick = (divisor != 16'h0000) & (baud_cnt_r == 16'h0000);
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			baud_cnt_r <= 16'h0000;
		else if ((divisor == 16'h0000) | div_wr)
			baud_cnt_r <= 16'h0000;
		else if (tick)
			baud_cnt_r <= divisor - 16'h0001;
		else
			baud_cnt_r <= baud_cnt_r - 16'h0001;
	end

	// ************************************************
	// Transmit shifter
	// ************************************************
	wire [3:0]  nb      = 4'h5 + {2'b00, line_format_r[1:0]};
	wire        par_en  = line_format_r[`UCRL_FMT_PAREN];
	wire [3:0]  flen    = 4'h1 + nb + {3'b000, par_en} + (line_format_r[`UCRL_FMT_STOP] ? 4'h2 : 4'h1);
	wire [11:0] hi_ones = 12'hFFF << nb;
	wire [11:0] tx_data = {4'h0, tx_holding_r} & ~hi_ones;
	wire        tx_par  = line_format_r[`UCRL_FMT_FORCE] ? ~line_format_r[`UCRL_FMT_EVEN] :
		(^tx_data) ^ ~line_format_r[`UCRL_FMT_EVEN];
	wire [11:0] tx_fram = par_en ? ((hi_ones & ~(12'h001 << nb)) | tx_data | ({11'h000, tx_par} << nb)) :
		(hi_ones | tx_data);
	reg  [11:0] tx_sh_r;
	reg  [3:0]  tx_left_r;
	reg         tx_busy_r;
	reg         tx_ser_r;
	assign tx_idle = ~thr_full_r & ~tx_busy_r;

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_sh_r   <= 12'hFFF;
			tx_left_r <= 4'h0;
			tx_busy_r <= 1'b0;
			tx_ser_r  <= 1'b1;
		end else if (tick) begin
			if (tx_busy_r) begin
				if (tx_left_r != 4'h0) begin
					tx_ser_r  <= tx_sh_r[0];
					tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
					tx_left_r <= tx_left_r - 4'h1;
				end else
					tx_busy_r <= 1'b0;
			end else if (thr_full_r) begin
				tx_ser_r  <= 1'b0;
				tx_sh_r   <= tx_fram;
				tx_left_r <= flen - 4'h1;
				tx_busy_r <= 1'b1;
			end
		end
	end
	wire tx_take = tick & ~tx_busy_r & thr_full_r;

	// ************************************************
	// Receive shifter
	// ************************************************
	wire        rx_line = loop ? tx_ser_r : rx_in;
	reg         rx_act_r;
	reg  [15:0] rx_tc_r;
	reg  [3:0]  rx_idx_r;
	reg  [7:0]  rx_sh_r;
	reg         rx_pbad_r;
	wire        rx_samp = rx_act_r & (rx_tc_r == 16'h0000);
	wire [3:0]  stop_ix = nb + 4'h1 + {3'b000, par_en};
	wire        rx_done = rx_samp & (rx_idx_r == stop_ix);
	wire [7:0]  rx_mask = ~hi_ones[7:0];
	wire        rx_exp  = line_format_r[`UCRL_FMT_FORCE] ? ~line_format_r[`UCRL_FMT_EVEN] :
		(^(rx_sh_r & rx_mask)) ^ ~line_format_r[`UCRL_FMT_EVEN];

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_act_r  <= 1'b0;
			rx_tc_r   <= 16'h0000;
			rx_idx_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_pbad_r <= 1'b0;
		end else if (!rx_act_r) begin
			if (~rx_line & (divisor != 16'h0000)) begin
				rx_act_r  <= 1'b1;
				rx_tc_r   <= divisor >> 1;
				rx_idx_r  <= 4'h0;
				rx_sh_r   <= 8'h00;
				rx_pbad_r <= 1'b0;
			end
		end else if (rx_samp) begin
			rx_tc_r  <= divisor - 16'h0001;
			rx_idx_r <= rx_idx_r + 4'h1;
			// A start bit that has gone high again was a glitch
			if ((rx_idx_r == 4'h0) & rx_line)
				rx_act_r <= 1'b0;
			else if ((rx_idx_r != 4'h0) & (rx_idx_r <= nb))
				rx_sh_r[rx_idx_r[2:0] - 3'h1] <= rx_line;
			else if (par_en & (rx_idx_r == nb + 4'h1))
				rx_pbad_r <= (rx_line != rx_exp);
			if (rx_done)
				rx_act_r <= 1'b0;
		end else
			rx_tc_r <= rx_tc_r - 16'h0001;
	end

	// ************************************************
	// Host writes, status flags and pins
	// ************************************************
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_q_r               <= 1'b1;
			wr_q_r               <= 1'b1;
			rdata                <= `UCRL_RST_BYTE;
			data_oe_n            <= 1'b1;
			line_format_r        <= `UCRL_RST_BYTE;
			modem_outputs_r      <= `UCRL_RST_BYTE;
			interrupt_mask_r     <= `UCRL_RST_BYTE;
			queue_control_r      <= `UCRL_RST_BYTE;
			divisor_low_r        <= `UCRL_RST_BYTE;
			divisor_high_r       <= `UCRL_RST_BYTE;
			alt_function_r       <= `UCRL_RST_BYTE;
			enhanced_features_r  <= `UCRL_RST_BYTE;
			resume_char_one_r    <= `UCRL_RST_BYTE;
			resume_char_two_r    <= `UCRL_RST_BYTE;
			pause_char_one_r     <= `UCRL_RST_BYTE;
			pause_char_two_r     <= `UCRL_RST_BYTE;
			scratch_r            <= `UCRL_RST_BYTE;
			tx_holding_r         <= `UCRL_RST_BYTE;
			rx_holding_r         <= `UCRL_RST_BYTE;
			thr_full_r           <= 1'b0;
			thre_int_r           <= 1'b0;
			rx_ready_r           <= 1'b0;
			overrun_r            <= 1'b0;
			par_err_r            <= 1'b0;
			frm_err_r            <= 1'b0;
			brk_r                <= 1'b0;
			mdm_prev_r           <= 4'h0;
			mdm_delta_r          <= 4'h0;
			tx_out               <= 1'b1;
			rts_n                <= 1'b1;
			dtr_n                <= 1'b1;
			general_output_two_n <= 1'b1;
		end else begin
			rd_q_r    <= rd_n;
			wr_q_r    <= wr_n;
			data_oe_n <= ~(sel & ~rd_n);
			if (rd_go)
				rdata <= rd_val;
			if (wr_go) begin
				case (addr)
					`UCRL_A_DATA:
						if (dlab)
							divisor_low_r <= wdata;
						else
							tx_holding_r <= wdata;
					`UCRL_A_MASK:
						if (dlab)
							divisor_high_r <= wdata;
						else
							interrupt_mask_r <= ext_en ? wdata : (wdata & `UCRL_EXT_MASK4);
					`UCRL_A_CAUSE:
						if (enh_view)
							enhanced_features_r <= wdata;
						else if (dlab)
							alt_function_r <= wdata;
						else
							// Reset bits act as pulses; bits 5:4 are never kept
							queue_control_r <= wdata & 8'hC9;
					`UCRL_A_FORMAT:
						line_format_r <= wdata;
					`UCRL_A_MODEM:
						if (enh_view)
							resume_char_one_r <= wdata;
						else
							modem_outputs_r <= ext_en ? wdata : (wdata & `UCRL_EXT_MASK5);
					`UCRL_A_LSTATE:
						if (enh_view)
							resume_char_two_r <= wdata;
					`UCRL_A_MSTATE:
						if (enh_view)
							pause_char_one_r <= wdata;
					`UCRL_A_SCRATCH:
						if (enh_view)
							pause_char_two_r <= wdata;
						else
							scratch_r <= wdata;
					default: ;
				endcase
			end

			// Holding register handshake; host load beats a same-cycle transfer
			if (wr_thr)
				thr_full_r <= 1'b1;
			else if (tx_take)
				thr_full_r <= 1'b0;
			if (tx_take & ~wr_thr)
				thre_int_r <= 1'b1;
			else if (wr_thr | (rd_isr & (cause_id == `UCRL_ID_TXE)))
				thre_int_r <= 1'b0;

			// Receive flags: a new event wins over a clearing read
			if (rx_done) begin
				rx_holding_r <= rx_sh_r & rx_mask;
				rx_ready_r   <= 1'b1;
			end else if (rd_rhr)
				rx_ready_r <= 1'b0;
			if (rx_done & rx_ready_r & ~rd_rhr)
				overrun_r <= 1'b1;
			else if (rd_lsr)
				overrun_r <= 1'b0;
			if (rx_done & rx_pbad_r)
				par_err_r <= 1'b1;
			else if (rd_lsr)
				par_err_r <= 1'b0;
			if (rx_done & ~rx_line)
				frm_err_r <= 1'b1;
			else if (rd_lsr)
				frm_err_r <= 1'b0;
			if (rx_done & ~rx_line & ((rx_sh_r & rx_mask) == 8'h00))
				brk_r <= 1'b1;
			else if (rd_lsr)
				brk_r <= 1'b0;

			mdm_prev_r  <= mdm_now;
			mdm_delta_r <= (rd_msr ? 4'h0 : mdm_delta_r) | mdm_chg;

			// No automatic request/clear-to-send pacing; pins follow the register, or are held high in loopback
			tx_out               <= loop | (tx_ser_r & ~line_format_r[`UCRL_FMT_BREAK]);
			rts_n                <= loop | ~modem_outputs_r[`UCRL_MDM_RTS];
			dtr_n                <= loop | ~modem_outputs_r[`UCRL_MDM_DTR];
			general_output_two_n <= loop | ~modem_outputs_r[`UCRL_MDM_OUT2];
		end
	end

endmodule // ucrl_top

// ---- dv/ucrl_monitor.sv ----
`timescale 1ns/1ps
module ucrl_monitor #(
	parameter       CHAN       = 1'h0,
	parameter [7:0] REV_CODE   = 8'h01,
	parameter [7:0] IDENT_CODE = 8'h5A
) (
	input wire       mclk,
	input wire       rstn,
	input wire       cs_n,
	input wire       channel_select,
	input wire [2:0] addr,
	input wire       rd_n,
	input wire       wr_n,
	input wire [7:0] wdata,
	input wire [7:0] rdata,
	input wire       data_oe_n,
	input wire       tx_out,
	input wire       rts_n,
	input wire       dtr_n,
	input wire       general_output_two_n
);
	// ********************
	// Register shadows
	// ********************
	reg  [7:0] fmt_r, mdm_r, spr_r, dl_r, dh_r;
	reg        rdq_r, wrq_r;
	reg  [2:0] quiet_r;
	wire       sel = !cs_n && (channel_select == CHAN);
	wire       tw  = sel && !wr_n && wrq_r;
	wire       tr  = sel && !rd_n && rdq_r;
	wire       bf  = (fmt_r == 8'hBF);
	wire       dvw = fmt_r[7] && !bf;
	wire       lp  = mdm_r[4];
	wire       dz  = ({dh_r, dl_r} == 16'h0000);

	// Pins are only judged once quiet_r shows the last write has had time to reach them
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{fmt_r, mdm_r, spr_r, dl_r, dh_r} <= 40'h0;
			{rdq_r, wrq_r} <= 2'h3;
			quiet_r <= 3'h0;
		end else begin
			rdq_r <= rd_n;
			wrq_r <= wr_n;
			quiet_r <= tw ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
			if (tw && addr == 3'h3) fmt_r <= wdata;
			if (tw && addr == 3'h4 && !bf) mdm_r <= wdata;
			if (tw && addr == 3'h7 && !bf) spr_r <= wdata;
			if (tw && addr == 3'h0 && fmt_r[7]) dl_r <= wdata;
			if (tw && addr == 3'h1 && fmt_r[7]) dh_r <= wdata;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_oe_drive; (sel && !rd_n) |=> !data_oe_n; endproperty
	a_oe_drive: assert property (p_oe_drive) else $error("bus not driven for read");
	property p_oe_off; !(sel && !rd_n) |=> data_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
	property p_loop_pins; lp && quiet_r >= 3'h4 |-> tx_out && rts_n && dtr_n && general_output_two_n; endproperty
	a_loop_pins: assert property (p_loop_pins) else $error("pins not idle in loopback");
	property p_mdm_pins;
		!lp && quiet_r >= 3'h4 |-> {rts_n, dtr_n, general_output_two_n} == ~{mdm_r[1], mdm_r[0], mdm_r[3]};
	endproperty
	a_mdm_pins: assert property (p_mdm_pins) else $error("modem pins wrong");
	property p_break; !lp && fmt_r[6] && quiet_r >= 3'h4 |-> !tx_out; endproperty
	a_break: assert property (p_break) else $error("break missing from line");
	property p_scratch; tr && addr == 3'h7 && !bf |=> rdata == spr_r; endproperty
	a_scratch: assert property (p_scratch) else $error("scratch read wrong");
	property p_fmt_read; tr && addr == 3'h3 |=> rdata == fmt_r; endproperty
	a_fmt_read: assert property (p_fmt_read) else $error("format read wrong");
	property p_ident; tr && dvw && dz && addr[2:1] == 2'h0 |=> rdata == ($past(addr[0]) ? IDENT_CODE : REV_CODE); endproperty
	a_ident: assert property (p_ident) else $error("code read wrong");
	property p_div_read; tr && dvw && !dz && addr[2:1] == 2'h0 |=> rdata == ($past(addr[0]) ? dh_r : dl_r); endproperty
	a_div_read: assert property (p_div_read) else $error("divisor read wrong");
	property p_loop_msr;
		lp && quiet_r >= 3'h4 && tr && addr == 3'h6 && !bf |=> rdata[7:4] == {mdm_r[3], 1'h0, mdm_r[0], mdm_r[1]};
	endproperty
	a_loop_msr: assert property (p_loop_msr) else $error("modem state not looped");

	c_loop: cover property (lp && tr && addr == 3'h6);
	c_ident: cover property (tr && dvw && dz);
	c_enh: cover property (tw && bf && addr == 3'h7);
endmodule // ucrl_monitor

// ---- dv/ucrl_host_model.sv ----
`timescale 1ns/1ps
module ucrl_host_model (
	input  wire       mclk,
	output reg        cs_n,
	output reg        channel_select,
	output reg  [2:0] addr,
	output reg        rd_n,
	output reg        wr_n,
	output reg  [7:0] wdata,
	input  wire [7:0] rdata
);
	// ********************
	// Host bus cycle
	// ********************
	initial begin
		{cs_n, rd_n, wr_n} = 3'h7;
		channel_select = 1'h0;
		addr = 3'h0;
		wdata = 8'h00;
	end

	// Strobe held two edges; the device acts at the first rising clock edge only once
	task acc(input ch, input rd, input [2:0] a, input [7:0] d, output [7:0] q);
		@(negedge mclk);
		{cs_n, channel_select, addr, wdata} = {1'h0, ch, a, d};
		{rd_n, wr_n} = {!rd, rd};
		repeat (2) @(negedge mclk);
		q = rdata;
		{cs_n, rd_n, wr_n} = 3'h7;
		// Released lines show the inverse so stale values never look live
		{addr, wdata} = ~{a, d};
	endtask
endmodule // ucrl_host_model

// ---- dv/ucrl_tb_top.sv ----
`timescale 1ns/1ps
`include "ucrl_regs.vh"
module ucrl_tb_top;
	localparam       CH  = 1'h1;
	localparam [7:0] REV = 8'h3C;  // Arbitrary value
	localparam [7:0] IDC = 8'hA7;  // Arbitrary value
	reg        mclk = 1'h0;
	reg        rstn = 1'h0;
	reg        cts_n = 1'h1;
	reg        dsr_n = 1'h1;
	reg        carrier_detect_n = 1'h1;
	reg        ring_indicate_n = 1'h1;
	wire       rx_in = 1'h1;
	wire       cs_n, channel_select, rd_n, wr_n, data_oe_n, tx_out, rts_n, dtr_n, general_output_two_n;
	wire [2:0] addr;
	wire [7:0] wdata, rdata;
	wire [7:0] pins = {4'h0, tx_out, rts_n, dtr_n, general_output_two_n};
	integer    seed = 71;
	integer    fail_count = 0;
	integer    total_checks = 0;
	integer    i, n;
	reg  [7:0] q, d, e, fmt;
	reg  [7:0] chr [4:7];

	always #4 mclk = ~mclk;

	ucrl_top #(.CHAN(CH), .REV_CODE(REV), .IDENT_CODE(IDC)) u_dut (.mclk, .rstn, .cs_n, .channel_select, .addr, .rd_n,
		.wr_n, .wdata, .rdata, .data_oe_n, .rx_in, .cts_n, .dsr_n, .carrier_detect_n, .ring_indicate_n, .tx_out,
		.rts_n, .dtr_n, .general_output_two_n);
	ucrl_host_model u_host (.mclk, .cs_n, .channel_select, .addr, .rd_n, .wr_n, .wdata, .rdata);

	// ********************
	// Expectations and checks
	// ********************
	function [7:0] ext_mask(input [7:0] v, input en);
		ext_mask = en ? v : (v & `UCRL_EXT_MASK4);
	endfunction
	function [7:0] loop_msr(input [7:0] m);
		loop_msr = {m[3], 1'h0, m[0], m[1], 4'h0};
	endfunction
	function [7:0] char_bits(input [7:0] v, input [1:0] wl);
		char_bits = v & (8'hFF >> (2'h3 - wl));
	endfunction
	function [7:0] cause(input fifo, input [7:0] id);
		cause = {{2{fifo}}, id[5:0]};
	endfunction
	task chk(input [8*8-1:0] nm, input [7:0] ex, input [7:0] got);
		total_checks = total_checks + 1;
		if (got !== ex) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %0s expected %h seen %h", nm, ex, got);
		end
	endtask
	task wr(input [2:0] a, input [7:0] v);
		u_host.acc(CH, 1'h0, a, v, q);
	endtask
	task rd(input [2:0] a);
		u_host.acc(CH, 1'h1, a, 8'h00, q);
	endtask
	task rdc(input [2:0] a, input [7:0] ex, input [8*8-1:0] nm);
		rd(a);
		chk(nm, ex, q);
	endtask
	task settle;
		repeat (4) @(negedge mclk);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge mclk);
		fail_count = fail_count + 1;
		complete_run;
	end

	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'h1;
		@(negedge mclk);
		chk("pins", 8'h0F, pins);
		rdc(3'h3, 8'h00, "format");
		rdc(3'h1, 8'h00, "mask");
		rdc(3'h4, 8'h00, "modem");
		rdc(3'h2, `UCRL_ID_NONE, "cause");
		// Other-channel traffic must leave this channel's scratch alone
		for (i = 0; i < 4; i = i + 1) begin
			d = 8'($random(seed));
			wr(3'h7, d);
			u_host.acc(!CH, 1'h0, 3'h7, ~d, q);
			u_host.acc(!CH, 1'h1, 3'h7, 8'h00, q);
			rdc(3'h7, d, "scratch");
		end
		rd(3'h5);
		e = q;
		wr(3'h5, ~e);
		rdc(3'h5, e, "lstate");
		wr(3'h3, 8'h80);
		rdc(3'h0, REV, "rev");
		rdc(3'h1, IDC, "ident");
		d = 8'($random(seed)) | 8'h01;
		e = 8'($random(seed));
		wr(3'h0, d);
		wr(3'h1, e);
		rdc(3'h0, d, "div_lo");
		rdc(3'h1, e, "div_hi");
		wr(3'h2, 8'h02);
		rdc(3'h2, 8'h02, "alt");
		wr(3'h0, 8'h04);
		wr(3'h1, 8'h00);
		wr(3'h3, `UCRL_ENH_KEY);
		wr(3'h2, 8'h10);
		for (i = 4; i < 8; i = i + 1) begin
			chr[i] = 8'($random(seed));
			wr(i[2:0], chr[i]);
		end
		for (i = 4; i < 8; i = i + 1) rdc(i[2:0], chr[i], "flow_chr");
		rdc(3'h2, 8'h10, "enh");
		rdc(3'h3, `UCRL_ENH_KEY, "format");
		for (i = 1; i >= 0; i = i - 1) begin
			wr(3'h3, `UCRL_ENH_KEY);
			wr(3'h2, {3'h0, i[0], 4'h0});
			wr(3'h3, 8'h03);
			wr(3'h1, 8'hF1);
			rdc(3'h1, ext_mask(8'hF1, i[0]), "mask");
			wr(3'h4, 8'hE0);
			rdc(3'h4, i[0] ? 8'hE0 : 8'h00, "modem");
		end
		wr(3'h2, 8'h01);
		rdc(3'h2, cause(1'h1, `UCRL_ID_NONE), "cause");
		wr(3'h4, 8'h0B);
		settle;
		chk("pins", 8'h08, pins);
		wr(3'h3, 8'h43);
		settle;
		chk("break", 8'h00, {7'h00, tx_out});
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h1B);
		settle;
		chk("pins", 8'h0F, pins);
		for (i = 0; i < 3; i = i + 1) begin
			{cts_n, dsr_n, carrier_detect_n, ring_indicate_n} = 4'($random(seed));
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			fmt = (i == 0) ? 8'h03 : (i == 1) ? 8'h1F : 8'h2A;
			wr(3'h3, fmt);
			wr(3'h0, d);
			q = 8'h00;
			for (n = 0; n < 60 && q[0] !== 1'h1; n = n + 1) rd(3'h5);
			if (q[0] !== 1'h1) begin
				fail_count = fail_count + 1;
				complete_run;
			end
			chk("lstate", 8'h01, q & 8'h1F);
			rdc(3'h2, cause(1'h1, `UCRL_ID_RXD), "cause");
			rdc(3'h0, char_bits(d, fmt[1:0]), "rx_data");
			rd(3'h6);
			chk("mstate", loop_msr(8'h1B), q & 8'hF0);
			wr(3'h6, ~q);
			rd(3'h6);
			chk("mstate", loop_msr(8'h1B), q & 8'hF0);
		end
		wr(3'h4, 8'h0B);
		settle;
		chk("pins", 8'h08, pins);
		complete_run;
	end
endmodule // ucrl_tb_top

bind ucrl_top ucrl_monitor #(.CHAN(CHAN), .REV_CODE(REV_CODE), .IDENT_CODE(IDENT_CODE)) u_mon (.mclk, .rstn, .cs_n,
	.channel_select, .addr, .rd_n, .wr_n, .wdata, .rdata, .data_oe_n, .tx_out, .rts_n, .dtr_n, .general_output_two_n);
